// *** hw/rcsm_top.sv ***
// Reset cause capture, reset source enables and supply monitor control.
// Assumes requesters on i_mclk except pin, comparator and supply level.
//
// Function
// - Cause bit 6 reads 1 after a flash access fault reset.
// - Cause bit 5 reads 1 after a comparator reset.
// - Writing 1 to cause bit 5 enables the active-low comparator reset.
// - Writing 1 to cause bit 4 forces a system reset at once.
// - Cause bit 4 reads 1 after a software forced reset.
// - Cause bit 3 reads 1 after a watchdog overflow reset.
// - Cause bit 2 reads 1 after a clock loss reset.
// - Writing 1 to cause bit 2 enables clock loss detector resets.
// - Cause bit 1 reads 1 after power-on or supply monitor reset.
// - Writing 1 to cause bit 1 selects supply monitor as reset source.
// - Cause bit 0 reads 1 after an external pin reset.
// - Reads return cause flags; writes go to enables and force logic.
// - With power-on flag set, other flags are meaningless.
// - Monitor must be enabled and settled before being selected.
// - Monitor control bit 7 turns the supply monitor off or on.
// - Enabled monitor resets only when also selected as a source.
// - Monitor bit 6 shows live supply level, 1 above threshold.
// - Non power resets clear the power-on flag.
// - Monitor enable and selection survive every device reset except power-on.
`timescale 1ns/1ps
module rcsm_top
  import rcsm_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // SFR bus
  input wire rcsm_sfr_req_type i_sfr_req,
  output logic [7:0] o_sfr_rdata,
  // Reset requesters on i_mclk
  input wire logic i_flash_fault,
  input wire logic i_wdt_ovf,
  input wire logic i_clk_loss,
  // Asynchronous inputs
  input wire logic i_rst_pin_n,
  input wire logic i_cmp_out,
  input wire logic i_supply_ok,
  // Control outputs
  output logic o_sys_reset,
  output logic o_supply_monitor_on,
  output logic o_clk_loss_detector_en,
  output logic o_cmp_reset_en
);

  // ************************************************
  // Decode
  // ************************************************
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
    addr_hit = (a == t);
  endfunction

  rcsm_state_type state_r;
  rcsm_cause_type capture_r;
  rcsm_cause_type flags_r;
  logic cmp_en_r;
  logic mcd_en_r;
  logic supply_on_r;
  logic supply_sel_r;
  logic pin_n_s;
  logic cmp_s;
  logic supply_ok_s;
  logic hold_done;

  wire in_run = (state_r == ST_RUN);
  // Core is held in reset, so bus writes during a hold are dropped; reads are still answered
  wire wr_cause = i_sfr_req.wr && in_run && addr_hit(i_sfr_req.addr, RCSM_CAUSE_ADDR);
  wire wr_smc = i_sfr_req.wr && in_run && addr_hit(i_sfr_req.addr, RCSM_SMC_ADDR);
  wire rd_cause = i_sfr_req.rd && addr_hit(i_sfr_req.addr, RCSM_CAUSE_ADDR);
  wire rd_smc = i_sfr_req.rd && addr_hit(i_sfr_req.addr, RCSM_SMC_ADDR);

  // ************************************************
  // Synchronisers and hold timer
  // ************************************************
  rcsm_sync #(
    .W(3),
    .RST_VAL(3'h7)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async({i_rst_pin_n, i_cmp_out, i_supply_ok}),
    .o_sync({pin_n_s, cmp_s, supply_ok_s})
  );

  // ************************************************
  // Reset requests
  // ************************************************
  rcsm_cause_type req;
  assign req.flash = i_flash_fault;
  assign req.cmp = cmp_en_r && !cmp_s;
  assign req.sw = wr_cause && i_sfr_req.wdata[RCSM_SW_BIT];
  assign req.wdt = i_wdt_ovf;
  assign req.clock_loss_detector = mcd_en_r && i_clk_loss;
  // Monitor needs both its own enable and source selection
  assign req.por = supply_on_r && supply_sel_r && !supply_ok_s;
  assign req.pin = !pin_n_s;
  wire any_req = |req;

  rcsm_hold_timer u_hold (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_load(any_req),
    .o_done(hold_done)
  );

  wire release_now = !in_run && !any_req && hold_done;

  // A power event makes the other causes meaningless, so they read zero
  wire rcsm_cause_type flags_nxt = capture_r.por ? RCSM_CAUSE_POR : capture_r;

  wire [7:0] rdata_nxt = rd_cause ? {1'b0, flags_r} :
                         rd_smc ? {supply_on_r, supply_ok_s, 6'h00} :
                         8'h00;

  // ************************************************
  // Sequencer
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_r <= ST_HOLD;
      capture_r <= RCSM_CAUSE_POR;
      o_sys_reset <= 1'b1;
    end else if (i_ce) begin
      if (in_run) begin
        if (any_req) begin
          state_r <= ST_HOLD;
          capture_r <= req;
          o_sys_reset <= 1'b1;
        end
      end else if (release_now) begin
        state_r <= ST_RUN;
        o_sys_reset <= 1'b0;
      end else begin
        // Sources that keep asserting during the hold also count
        capture_r <= capture_r | req;
      end
    end
  end

  // ************************************************
  // Cause flags
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flags_r <= RCSM_CAUSE_NONE;
    end else if (i_ce && release_now) begin
      flags_r <= flags_nxt;
    end
  end

  // ************************************************
  // Source enables
  // ************************************************
  // Comparator and clock loss enables drop on every device reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cmp_en_r <= RCSM_CMPEN_RST;
      mcd_en_r <= RCSM_MCDEN_RST;
    end else if (i_ce) begin
      if (in_run && any_req) begin
        cmp_en_r <= RCSM_CMPEN_RST;
        mcd_en_r <= RCSM_MCDEN_RST;
      end else if (wr_cause) begin
        cmp_en_r <= i_sfr_req.wdata[RCSM_CMP_BIT];
        mcd_en_r <= i_sfr_req.wdata[RCSM_MCD_BIT];
      end
    end
  end

  // Supply monitor state is only touched by power-on and software
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      supply_on_r <= RCSM_SMON_RST;
      supply_sel_r <= RCSM_SSEL_RST;
    end else if (i_ce) begin
      if (wr_cause) begin
        // Selecting an unsettled monitor may reset at once; software waits
        supply_sel_r <= i_sfr_req.wdata[RCSM_POR_BIT];
      end
      if (wr_smc) begin
        supply_on_r <= i_sfr_req.wdata[RCSM_SMON_BIT];
      end
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= RCSM_RDATA_RST;
      o_supply_monitor_on <= RCSM_SMON_RST;
      o_clk_loss_detector_en <= RCSM_MCDEN_RST;
      o_cmp_reset_en <= RCSM_CMPEN_RST;
    end else if (i_ce) begin
      o_sfr_rdata <= rdata_nxt;
      o_supply_monitor_on <= supply_on_r;
      o_clk_loss_detector_en <= mcd_en_r;
      o_cmp_reset_en <= cmp_en_r;
    end
  end

  // ************************************************
  // Assertion helpers
  // ************************************************
  // Software force seen, kept until the hold that it started ends
  logic sw_pend_r;
  // Quiet cycles in the hold, counted apart from the hold timer
  logic [RCSM_CNT_W-1:0] quiet_cnt_r;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sw_pend_r <= 1'b0;
    end else if (i_ce) begin
      if (release_now) begin
        sw_pend_r <= 1'b0;
      end else if (in_run && wr_cause && i_sfr_req.wdata[RCSM_SW_BIT]) begin
        sw_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      quiet_cnt_r <= '0;
    end else if (i_ce) begin
      if (in_run || any_req) begin
        quiet_cnt_r <= '0;
      end else if (quiet_cnt_r != '1) begin
        quiet_cnt_r <= quiet_cnt_r + 1'b1;
      end
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst || !i_ce);

  sequence sw_force_s;
    in_run && wr_cause && i_sfr_req.wdata[RCSM_SW_BIT];
  endsequence

  sequence hold_exit_s;
    release_now ##1 in_run;
  endsequence

  sequence hold_entry_s;
    in_run && any_req;
  endsequence

  sw_force_a: assert property (sw_force_s |=> o_sys_reset && capture_r.sw)
    else $error("Software force did not reset");

  sw_flag_a: assert property (release_now && sw_pend_r |=> flags_r.sw || flags_r.por)
    else $error("Software flag missing after forced reset");

  flag_hold_a: assert property (in_run && $past(in_run) && $past(i_ce) |-> $stable(flags_r))
    else $error("Cause flags changed outside reset");

  por_clear_a: assert property (release_now && !capture_r.por |=> !flags_r.por)
    else $error("Power flag not cleared");

  por_only_a: assert property (release_now && capture_r.por |=> flags_r == RCSM_CAUSE_POR)
    else $error("Power flag without clean other flags");

  smon_gate_a: assert property (!supply_sel_r || !supply_on_r |-> !req.por)
    else $error("Unselected monitor requested reset");

  smon_keep_a: assert property (!in_run && !$past(in_run) && $past(i_ce)
    |-> $stable(supply_on_r) && $stable(supply_sel_r))
    else $error("Monitor state changed by reset");

  level_read_a: assert property (rd_smc |=> o_sfr_rdata[RCSM_SLVL_BIT] == $past(supply_ok_s))
    else $error("Supply level readback wrong");

  cause_read_a: assert property (rd_cause |=> o_sfr_rdata == {1'b0, $past(flags_r)})
    else $error("Cause readback wrong");

  mcd_trig_a: assert property (in_run && mcd_en_r && i_clk_loss |=> o_sys_reset ##0 capture_r.clock_loss_detector)
    else $error("Clock loss did not reset");

  pin_exit_a: assert property (hold_exit_s |-> $past(capture_r.por) ||
    flags_r.pin == $past(capture_r.pin, 2))
    else $error("Pin flag not latched");

  hold_min_a: assert property (release_now |-> quiet_cnt_r >= RCSM_CNT_W'(RCSM_HOLD_CYC))
    else $error("Reset released too early");

  hold_max_a: assert property (!in_run |-> quiet_cnt_r <= RCSM_CNT_W'(RCSM_HOLD_CYC))
    else $error("Reset held too long");

  cmp_trig_a: assert property (in_run && cmp_en_r && !cmp_s |=> o_sys_reset && capture_r.cmp)
    else $error("Comparator did not reset");

  wdt_trig_a: assert property (in_run && i_wdt_ovf |=> o_sys_reset && capture_r.wdt)
    else $error("Watchdog did not reset");

  flash_trig_a: assert property (in_run && i_flash_fault |=> o_sys_reset && capture_r.flash)
    else $error("Flash fault did not reset");

  cause_exit_a: assert property (release_now && !capture_r.por |=> flags_r == $past(capture_r))
    else $error("Cause flags not latched at release");

  rdata_idle_a: assert property (!i_sfr_req.rd |=> o_sfr_rdata == 8'h00)
    else $error("Read data not idle");

  en_drop_a: assert property (hold_entry_s |=> !cmp_en_r && !mcd_en_r)
    else $error("Source enables kept through reset");

  smon_write_a: assert property (wr_smc |=> supply_on_r == $past(i_sfr_req.wdata[RCSM_SMON_BIT]))
    else $error("Monitor enable write lost");

  smon_sel_a: assert property (wr_cause |=> supply_sel_r == $past(i_sfr_req.wdata[RCSM_POR_BIT]))
    else $error("Monitor select write lost");

endmodule

// *** pkg/rcsm_pkg.sv ***
// Constants and carrier types for the reset cause / supply monitor block.
// Assumes an 8-bit special function register bus clocked by i_mclk.
package rcsm_pkg;

  // ************************************************
  // Register offsets on the SFR bus
  // ************************************************
  localparam logic [7:0] RCSM_CAUSE_ADDR = 8'hEF;
  localparam logic [7:0] RCSM_SMC_ADDR = 8'hFF;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int RCSM_CMP_BIT = 5;
  localparam int RCSM_SW_BIT = 4;
  localparam int RCSM_MCD_BIT = 2;
  localparam int RCSM_POR_BIT = 1;
  localparam int RCSM_SMON_BIT = 7;
  localparam int RCSM_SLVL_BIT = 6;

  // ************************************************
  // Values after power-on
  // ************************************************
  localparam logic RCSM_SMON_RST = 1'b1;
  localparam logic RCSM_SSEL_RST = 1'b1;
  localparam logic RCSM_CMPEN_RST = 1'b0;
  localparam logic RCSM_MCDEN_RST = 1'b0;
  localparam logic [7:0] RCSM_RDATA_RST = 8'h00;

  // ************************************************
  // Timing
  // ************************************************
  localparam int RCSM_CLK_NS = 10;
  // Least time the core is held in reset after the last request drops
  localparam int RCSM_HOLD_NS = 160;
  localparam int RCSM_HOLD_CYC = (RCSM_HOLD_NS + RCSM_CLK_NS - 1) / RCSM_CLK_NS;
  localparam int RCSM_CNT_W = 8;

  // ************************************************
  // Carrier types
  // ************************************************
  typedef struct packed {
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic clock_loss_detector;
    logic por;
    logic pin;
  } rcsm_cause_type;

  localparam rcsm_cause_type RCSM_CAUSE_NONE = 7'h00;
  localparam rcsm_cause_type RCSM_CAUSE_POR = 7'h02;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcsm_sfr_req_type;

  typedef enum logic {ST_RUN, ST_HOLD} rcsm_state_type;

endpackage

// *** hw/rcsm_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are slow levels; a pulse shorter than one cycle may be missed.
`timescale 1ns/1ps
module rcsm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// *** hw/rcsm_hold_timer.sv ***
// Down-counter that stretches the device reset to a minimum length.
// Reloads every cycle that i_load is high; o_done once it reaches zero.
`timescale 1ns/1ps
module rcsm_hold_timer
  import rcsm_pkg::*;
(
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Timer
  input wire logic i_load,
  output logic o_done
);

  localparam logic [RCSM_CNT_W-1:0] LOAD_VAL = RCSM_CNT_W'(RCSM_HOLD_CYC);

  logic [RCSM_CNT_W-1:0] cnt_r;

  assign o_done = (cnt_r == '0);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cnt_r <= LOAD_VAL;
    end else if (i_ce) begin
      if (i_load) begin
        cnt_r <= LOAD_VAL;
      end else if (!o_done) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// *** verif/rcsm_core_model.sv ***
// Processor core model that reaches the reset cause block over the SFR bus.
// Assumes the block takes a strobe at a rising edge and answers a read one edge later.
`timescale 1ns/1ps
module rcsm_core_model
  import rcsm_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // SFR bus
  input wire logic [7:0] i_sfr_rdata,
  output rcsm_sfr_req_type o_sfr_req
);
  // ************************************************
  // Bus cycles
  // ************************************************
  localparam int SETTLE_CYC = 8;

  initial o_sfr_req = '0;

  // Write data is built from intent only, never from read-back flags
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == RCSM_CAUSE_ADDR) d[7] = 1'b0;
    if (addr == RCSM_SMC_ADDR) d[5:0] = 6'h00;
    @(negedge i_mclk);
    o_sfr_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(negedge i_mclk);
    o_sfr_req = '0;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_mclk);
    o_sfr_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge i_mclk);
    data = i_sfr_rdata;
    o_sfr_req = '0;
  endtask

  // Selecting an unsettled monitor could reset the part, so enable first
  task automatic select_monitor(input logic [7:0] enables);
    write_reg(RCSM_SMC_ADDR, 8'h80);
    repeat (SETTLE_CYC) @(negedge i_mclk);
    write_reg(RCSM_CAUSE_ADDR, enables | 8'h02);
  endtask
endmodule

// *** verif/rcsm_top_tb_top.sv ***
// Self-checking bench for the reset cause and supply monitor block.
// Assumes the core model drives the SFR bus; requesters are driven here.
`timescale 1ns/1ps
module rcsm_top_tb_top;
  import rcsm_pkg::*;
  logic i_mclk, i_sys_rst, i_ce, i_flash_fault, i_wdt_ovf, i_clk_loss;
  logic i_rst_pin_n, i_cmp_out, i_supply_ok;
  logic o_sys_reset, o_supply_monitor_on, o_clk_loss_detector_en, o_cmp_reset_en;
  logic [7:0] o_sfr_rdata, rd;
  rcsm_sfr_req_type sfr_req;
  int fail_count = 0;
  int n_checks = 0;

  rcsm_top dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_sfr_req(sfr_req),
    .o_sfr_rdata(o_sfr_rdata), .i_flash_fault(i_flash_fault), .i_wdt_ovf(i_wdt_ovf),
    .i_clk_loss(i_clk_loss), .i_rst_pin_n(i_rst_pin_n), .i_cmp_out(i_cmp_out),
    .i_supply_ok(i_supply_ok), .o_sys_reset(o_sys_reset), .o_supply_monitor_on(o_supply_monitor_on),
    .o_clk_loss_detector_en(o_clk_loss_detector_en), .o_cmp_reset_en(o_cmp_reset_en));
  rcsm_core_model core (.i_mclk(i_mclk), .i_sfr_rdata(o_sfr_rdata), .o_sfr_req(sfr_req));

  // ************************************************
  // Helpers
  // ************************************************
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded waits: entry into reset, then release, then the cause read
  task automatic expect_reset(input logic [7:0] cause);
    int n;
    n = 0;
    while (o_sys_reset !== 1'b1 && n < 8) begin
      @(negedge i_mclk);
      n++;
    end
    check({7'h00, o_sys_reset}, 8'h01);
    n = 0;
    while (o_sys_reset !== 1'b0 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    check({7'h00, o_sys_reset}, 8'h00);
    core.read_reg(RCSM_CAUSE_ADDR, rd);
    check(rd, cause);
  endtask

  task automatic expect_quiet();
    repeat (8) @(negedge i_mclk);
    check({7'h00, o_sys_reset}, 8'h00);
  endtask

  // ************************************************
  // Tests
  // ************************************************
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    {i_flash_fault, i_wdt_ovf, i_clk_loss} = 3'h0;
    {i_rst_pin_n, i_cmp_out, i_supply_ok} = 3'h7;
    i_ce = 1'b1;
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    expect_reset(8'h02);
    core.read_reg(RCSM_SMC_ADDR, rd);
    check(rd, 8'hC0);
    core.read_reg(8'h80, rd);
    check(rd, 8'h00);
    core.write_reg(RCSM_CAUSE_ADDR, 8'h12);
    core.write_reg(RCSM_SMC_ADDR, 8'h00);
    expect_reset(8'h10);
    check({7'h00, o_supply_monitor_on}, 8'h01);
    @(negedge i_mclk) i_wdt_ovf = 1'b1;
    @(negedge i_mclk) i_wdt_ovf = 1'b0;
    expect_reset(8'h08);
    @(negedge i_mclk) i_flash_fault = 1'b1;
    @(negedge i_mclk) i_flash_fault = 1'b0;
    expect_reset(8'h40);
    @(negedge i_mclk) i_rst_pin_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_rst_pin_n = 1'b1;
    expect_reset(8'h01);
    i_clk_loss = 1'b1;
    expect_quiet();
    i_clk_loss = 1'b0;
    core.write_reg(RCSM_CAUSE_ADDR, 8'h06);
    @(negedge i_mclk);
    check({7'h00, o_clk_loss_detector_en}, 8'h01);
    i_clk_loss = 1'b1;
    @(negedge i_mclk) i_clk_loss = 1'b0;
    expect_reset(8'h04);
    check({7'h00, o_clk_loss_detector_en}, 8'h00);
    core.write_reg(RCSM_CAUSE_ADDR, 8'h22);
    @(negedge i_mclk);
    check({7'h00, o_cmp_reset_en}, 8'h01);
    i_cmp_out = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_cmp_out = 1'b1;
    expect_reset(8'h20);
    i_supply_ok = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_supply_ok = 1'b1;
    expect_reset(8'h02);
    core.write_reg(RCSM_CAUSE_ADDR, 8'h00);
    i_supply_ok = 1'b0;
    expect_quiet();
    core.read_reg(RCSM_SMC_ADDR, rd);
    check(rd, 8'h80);
    i_supply_ok = 1'b1;
    core.write_reg(RCSM_SMC_ADDR, 8'h00);
    core.read_reg(RCSM_SMC_ADDR, rd);
    check(rd, 8'h40);
    core.write_reg(RCSM_CAUSE_ADDR, 8'h10);
    expect_reset(8'h10);
    core.read_reg(RCSM_SMC_ADDR, rd);
    check(rd, 8'h40);
    core.select_monitor(8'h00);
    core.read_reg(RCSM_SMC_ADDR, rd);
    check(rd, 8'hC0);
    i_supply_ok = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_supply_ok = 1'b1;
    expect_reset(8'h02);
    // A request while the clock enable is low must leave no trace
    i_ce = 1'b0;
    @(negedge i_mclk) i_wdt_ovf = 1'b1;
    @(negedge i_mclk) i_wdt_ovf = 1'b0;
    i_ce = 1'b1;
    expect_quiet();
    core.read_reg(RCSM_CAUSE_ADDR, rd);
    check(rd, 8'h02);
    end_of_test();
  end
endmodule
